// ===== hw/ccp_mode_control_defines.svh
// Named offsets, field positions, codes and reset values of the unit.
`ifndef CCP_MODE_CONTROL_DEFINES_SVH
`define CCP_MODE_CONTROL_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave.
`define CCP_OFS_CTRL        8'h00
`define CCP_OFS_DUTY_HI     8'h04
`define CCP_OFS_STATUS      8'h08
`define CCP_OFS_CLEAR       8'h0C
`define CCP_OFS_ENABLE      8'h10
`define CCP_OFS_STATE       8'h14

// Field positions inside the control register.
`define CCP_CTRL_MODE_LSB   0
`define CCP_CTRL_MODE_MSB   3
`define CCP_CTRL_DUTY_LSB   4
`define CCP_CTRL_DUTY_MSB   5

// Event bits of the status, clear and enable registers.
`define CCP_EV_MATCH        0
`define CCP_EV_TRIG         1

// Bits of the read-only state register.
`define CCP_STATE_PIN_OUT   0
`define CCP_STATE_PIN_IN    1
`define CCP_STATE_UNIT_OFF  2

// Mode select codes.
`define CCP_MODE_OFF        4'h0
`define CCP_MODE_CAP_FALL   4'h4
`define CCP_MODE_CAP_RISE   4'h5
`define CCP_MODE_CAP_RISE4  4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_CMP_SET    4'h8
`define CCP_MODE_CMP_CLR    4'h9
`define CCP_MODE_CMP_SWI    4'hA
`define CCP_MODE_CMP_TRIG   4'hB
`define CCP_GRP_CAPTURE     2'h1
`define CCP_GRP_COMPARE     2'h2
`define CCP_GRP_PWM         2'h3

// Edge prescaler terminal counts.
`define CCP_PS4_LAST        4'h3
`define CCP_PS16_LAST       4'hF
`define CCP_PS_ZERO         4'h0
`define CCP_PS_ONE          4'h1

// Reset values.
`define CCP_CTRL_RST        6'h00
`define CCP_DUTY_HI_RST     8'h00
`define CCP_EV_RST          2'h0
`define CCP_DUTY_RST        10'h000

// AHB-Lite encodings.
`define CCP_HTRANS_ACT_BIT  1
`define CCP_HRESP_OKAY      1'h0

`endif

// ===== hw/ccp_pkg.sv
// Types shared by the capture/compare mode control unit.
package ccp_pkg;

  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] mode_select;
  } ccp_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] offset;
  } ccp_ahb_addr_t;

  typedef struct packed {
    logic trig;
    logic match;
  } ccp_events_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ccp_pin_t;

endpackage : ccp_pkg

// ===== hw/ccp_pin_sync.sv
// Three-stage synchroniser and edge detector for the capture pin.
module ccp_pin_sync
  import ccp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic     sys_clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     ce_in,
  // Pin and result.
  input  wire logic     pin_in,
  output ccp_pin_t      pin_out
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       level_reg;
  logic       level_next;

  // A change counts only once the second and third stages agree.
  always_comb begin
    sync_next  = {sync_reg[1:0], pin_in};
    level_next = level_reg;
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'h0;
    end else if (ce_in) begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign pin_out.level = level_reg;
  assign pin_out.rise  = ce_in & level_next & ~level_reg;
  assign pin_out.fall  = ce_in & ~level_next & level_reg;

endmodule : ccp_pin_sync

// ===== hw/ccp_capture_prescale.sv
// Capture edge selection with the rising edge prescale counter.
module ccp_capture_prescale
  import ccp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Mode and edges.
  input  wire logic [3:0] mode_in,
  input  ccp_pin_t        pin_in,
  // Capture decision.
  output logic            capture_out
);

  `include "ccp_mode_control_defines.svh"

  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic       is_capture;
  logic [3:0] last_count;

  assign is_capture = (mode_in[3:2] == `CCP_GRP_CAPTURE);
  assign last_count = (mode_in == `CCP_MODE_CAP_RISE16) ? `CCP_PS16_LAST
                                                        : `CCP_PS4_LAST;

  always_comb begin
    count_next  = count_reg;
    capture_out = 1'b0;
    if (!is_capture) begin
      // The counter is held clear whenever the unit is off or not capturing.
      count_next = `CCP_PS_ZERO;
    end else begin
      unique case (mode_in)
        `CCP_MODE_CAP_FALL: begin
          capture_out = pin_in.fall;
        end
        `CCP_MODE_CAP_RISE: begin
          capture_out = pin_in.rise;
        end
        `CCP_MODE_CAP_RISE4, `CCP_MODE_CAP_RISE16: begin
          if (pin_in.rise) begin
            if (count_reg == last_count) begin
              count_next  = `CCP_PS_ZERO;
              capture_out = 1'b1;
            end else begin
              count_next = count_reg + `CCP_PS_ONE;
            end
          end
        end
        default: begin
          capture_out = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count_reg <= `CCP_PS_ZERO;
    end else if (ce_in) begin
      count_reg <= count_next;
    end
  end

endmodule : ccp_capture_prescale

// ===== hw/ccp_mode_control.sv
// Control register, mode decoder and event logic of the capture/compare unit.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
module ccp_mode_control
  import ccp_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // AHB-Lite slave.
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Unit pins and datapath links.
  input  wire logic        capture_pin_in,
  input  wire logic        cmp_match_in,
  input  wire logic        adc_enable_in,
  output logic             compare_pin_out,
  output logic             capture_strobe_out,
  output logic             timer_reset_out,
  output logic             adc_start_out,
  output logic             pwm_mode_out,
  output logic [9:0]       pwm_duty_out,
  output logic             unit_reset_out,
  // Interrupt.
  output logic             irq_out
);

  `include "ccp_mode_control_defines.svh"

  // Bus address phase and read data.
  ccp_ahb_addr_t addr_reg;
  ccp_ahb_addr_t addr_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;

  // Software registers.
  ccp_ctrl_t     ctrl_reg;
  ccp_ctrl_t     ctrl_next;
  logic [7:0]    duty_hi_reg;
  logic [7:0]    duty_hi_next;
  ccp_events_t   status_reg;
  ccp_events_t   status_next;
  ccp_events_t   enable_reg;
  ccp_events_t   enable_next;
  logic          irq_reg;
  logic          irq_next;

  // Unit outputs.
  logic          pin_out_reg;
  logic          pin_out_next;
  logic          strobe_reg;
  logic          strobe_next;
  logic          trig_reg;
  logic          trig_next;
  logic          adc_reg;
  logic          adc_next;
  logic [9:0]    duty_reg;
  logic [9:0]    duty_next;
  logic          off_reg;
  logic          off_next;
  logic          pwm_reg;
  logic          pwm_next;

  // Decode and event terms.
  ccp_pin_t      pin_sync;
  logic          cap_hit;
  logic          cmp_hit;
  logic          is_off;
  logic          is_compare;
  logic          is_pwm;
  logic          addr_take;
  logic          wr_en;
  ccp_events_t   events;
  ccp_events_t   clear_mask;
  logic [3:0]    mode;

  // The capture pin is asynchronous; only its synchronised level and edges
  // are used below.
  ccp_pin_sync u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .pin_in     (capture_pin_in),
    .pin_out    (pin_sync)
  );

  // The prescaler clears itself whenever the unit leaves capture mode.
  ccp_capture_prescale u_prescale (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .mode_in     (mode),
    .pin_in      (pin_sync),
    .capture_out (cap_hit)
  );

  // Codes 0001 to 0011 fall in no group, so the unit idles with no events.
  assign mode       = ctrl_reg.mode_select;
  assign is_off     = (mode == `CCP_MODE_OFF);
  assign is_compare = (mode[3:2] == `CCP_GRP_COMPARE);
  assign is_pwm     = (mode[3:2] == `CCP_GRP_PWM);
  // A match counts only in the compare group and while the clock runs.
  assign cmp_hit    = ce_in & cmp_match_in & is_compare;

  // The slave never stalls, except that a low enable freezes the bus too.
  assign hreadyout_out = ce_in;
  assign hresp_out     = `CCP_HRESP_OKAY;
  assign hrdata_out    = rdata_reg;

  assign addr_take = hsel_in & htrans_in[`CCP_HTRANS_ACT_BIT] & hready_in;
  assign wr_en     = addr_reg.valid & addr_reg.write;

  // Address phase capture and read data, ready for the data phase.
  // Read data is fetched in the address phase, so a read whose address
  // phase overlaps the data phase of a write to the same register returns
  // the old value.
  always_comb begin
    addr_next  = addr_reg;
    rdata_next = rdata_reg;
    if (hready_in) begin
      addr_next.valid  = addr_take;
      addr_next.write  = hwrite_in;
      addr_next.offset = haddr_in[7:0];
    end
    if (addr_take && !hwrite_in) begin
      rdata_next = 32'h0000_0000;
      unique case (haddr_in[7:0])
        `CCP_OFS_CTRL: begin
          // Bits seven and six are not stored and read as zero.
          rdata_next[5:0] = ctrl_reg;
        end
        `CCP_OFS_DUTY_HI: begin
          rdata_next[7:0] = duty_hi_reg;
        end
        `CCP_OFS_STATUS: begin
          rdata_next[1:0] = status_reg;
        end
        `CCP_OFS_ENABLE: begin
          rdata_next[1:0] = enable_reg;
        end
        `CCP_OFS_CLEAR: begin
          // The clear register is write-only and reads as zero.
          rdata_next = 32'h0000_0000;
        end
        `CCP_OFS_STATE: begin
          rdata_next[`CCP_STATE_PIN_OUT]  = pin_out_reg;
          rdata_next[`CCP_STATE_PIN_IN]   = pin_sync.level;
          rdata_next[`CCP_STATE_UNIT_OFF] = off_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      addr_reg  <= '0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      addr_reg  <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes land at the end of the data phase.
  always_comb begin
    ctrl_next    = ctrl_reg;
    duty_hi_next = duty_hi_reg;
    enable_next  = enable_reg;
    clear_mask   = `CCP_EV_RST;
    if (wr_en) begin
      unique case (addr_reg.offset)
        `CCP_OFS_CTRL: begin
          ctrl_next.mode_select =
            hwdata_in[`CCP_CTRL_MODE_MSB:`CCP_CTRL_MODE_LSB];
          ctrl_next.duty_low_bits =
            hwdata_in[`CCP_CTRL_DUTY_MSB:`CCP_CTRL_DUTY_LSB];
        end
        `CCP_OFS_DUTY_HI: begin
          duty_hi_next = hwdata_in[7:0];
        end
        `CCP_OFS_CLEAR: begin
          clear_mask = hwdata_in[1:0];
        end
        `CCP_OFS_ENABLE: begin
          enable_next = hwdata_in[1:0];
        end
        `CCP_OFS_STATUS, `CCP_OFS_STATE: begin
          // Both registers are read-only, so a write leaves them alone.
          ctrl_next = ctrl_reg;
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_comb begin
    events.match = cap_hit | cmp_hit;
    events.trig  = cmp_hit & (mode == `CCP_MODE_CMP_TRIG);
    // Clearing is write-one: a zero bit in the clear word leaves its flag.
    status_next  = (status_reg & ~clear_mask) | events;
    irq_next     = |(status_next & enable_next);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_reg    <= `CCP_CTRL_RST;
      duty_hi_reg <= `CCP_DUTY_HI_RST;
      enable_reg  <= `CCP_EV_RST;
      status_reg  <= `CCP_EV_RST;
      irq_reg     <= 1'b0;
    end else if (ce_in) begin
      ctrl_reg    <= ctrl_next;
      duty_hi_reg <= duty_hi_next;
      enable_reg  <= enable_next;
      status_reg  <= status_next;
      irq_reg     <= irq_next;
    end
  end

  // Registered from the next values, so the interrupt rises in the same
  // cycle as the flag that raises it.
  assign irq_out = irq_reg;

  // Compare output latch, capture strobe, trigger and PWM duty.
  always_comb begin
    pin_out_next = pin_out_reg;
    // The off mode forces the latch to its default low level.
    if (is_off) begin
      pin_out_next = 1'b0;
    end else if (cmp_hit && mode == `CCP_MODE_CMP_SET) begin
      pin_out_next = 1'b1;
    end else if (cmp_hit && mode == `CCP_MODE_CMP_CLR) begin
      pin_out_next = 1'b0;
    end
    // Software interrupt and trigger modes leave the latch alone.
    strobe_next = cap_hit;
    trig_next   = events.trig;
    adc_next    = events.trig & adc_enable_in;
    off_next    = is_off;
    pwm_next    = is_pwm;
    // Outside PWM the duty word is zero, so no stale value leaks out.
    duty_next   = `CCP_DUTY_RST;
    if (is_pwm) begin
      duty_next = {duty_hi_reg, ctrl_reg.duty_low_bits};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pin_out_reg <= 1'b0;
      strobe_reg  <= 1'b0;
      trig_reg    <= 1'b0;
      adc_reg     <= 1'b0;
      duty_reg    <= `CCP_DUTY_RST;
      off_reg     <= 1'b1;
      pwm_reg     <= 1'b0;
    end else if (ce_in) begin
      pin_out_reg <= pin_out_next;
      strobe_reg  <= strobe_next;
      trig_reg    <= trig_next;
      adc_reg     <= adc_next;
      duty_reg    <= duty_next;
      off_reg     <= off_next;
      pwm_reg     <= pwm_next;
    end
  end

  assign compare_pin_out    = pin_out_reg;
  assign capture_strobe_out = strobe_reg;
  assign timer_reset_out    = trig_reg;
  assign adc_start_out      = adc_reg;
  assign pwm_mode_out       = pwm_reg;
  assign pwm_duty_out       = duty_reg;
  assign unit_reset_out     = off_reg;

endmodule : ccp_mode_control

// ===== dv/ccp_mode_control_assertions.sv
// Assertion checker bound to the capture/compare mode control unit.
module ccp_mode_control_assertions (
  // Clock, reset and enable.
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       ce_in,
  // Unit inputs.
  input wire logic       cmp_match_in,
  input wire logic       adc_enable_in,
  // Watched outputs.
  input wire logic       hreadyout_out,
  input wire logic       hresp_out,
  input wire logic       compare_pin_out,
  input wire logic       capture_strobe_out,
  input wire logic       timer_reset_out,
  input wire logic       adc_start_out,
  input wire logic       pwm_mode_out,
  input wire logic [9:0] pwm_duty_out,
  input wire logic       unit_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ready_follows_ce: assert property (hreadyout_out == ce_in)
    else $error("ready does not follow clock enable");
  a_resp_okay: assert property (hresp_out == 1'h0)
    else $error("response is not okay");
  a_trig_needs_match: assert property (
    timer_reset_out |-> $past(cmp_match_in))
    else $error("trigger without a match");
  a_adc_with_trig: assert property (
    adc_start_out |-> timer_reset_out && $past(adc_enable_in))
    else $error("converter start without enabled trigger");
  a_adc_when_enabled: assert property (
    timer_reset_out && $past(adc_enable_in) |-> adc_start_out)
    else $error("enabled trigger gave no converter start");
  a_pin_needs_match: assert property (
    $changed(compare_pin_out) && !$past(cmp_match_in) |->
      ##[0:1] unit_reset_out)
    else $error("compare output moved without a match");
  a_off_quiet: assert property (
    unit_reset_out && $past(unit_reset_out) |->
      !compare_pin_out && !capture_strobe_out && !timer_reset_out)
    else $error("disabled unit is not quiet");
  a_pwm_not_off: assert property (
    pwm_mode_out && $past(pwm_mode_out) |-> !unit_reset_out)
    else $error("pwm mode while unit held off");
  a_duty_idle_zero: assert property (
    !pwm_mode_out && !$past(pwm_mode_out) |-> pwm_duty_out == 10'h000)
    else $error("duty value outside pwm mode");
  a_strobes_apart: assert property (
    capture_strobe_out |-> !timer_reset_out)
    else $error("capture and trigger together");
endmodule : ccp_mode_control_assertions

// ===== dv/ccp_mode_control_decode_test.sv
// Self-checking testbench for the capture/compare mode control unit.
`include "ccp_mode_control_defines.svh"
module ccp_mode_control_decode_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        ce_in      = 1'b1;
  logic        hsel_in    = 1'b1;
  logic [31:0] haddr_in   = 32'h0;
  logic [1:0]  htrans_in  = 2'h0;
  logic        hwrite_in  = 1'b0;
  logic [2:0]  hsize_in   = 3'h2;
  logic [31:0] hwdata_in  = 32'h0;
  wire logic   hready_in;
  logic        capture_pin_in = 1'b0;
  logic        cmp_match_in   = 1'b0;
  logic        adc_enable_in  = 1'b0;
  logic        hreadyout_out, hresp_out, compare_pin_out;
  logic        capture_strobe_out, timer_reset_out, adc_start_out;
  logic        pwm_mode_out, unit_reset_out, irq_out;
  logic [31:0] hrdata_out;
  logic [9:0]  pwm_duty_out;
  int          bad_count, check_count, caps;

  assign hready_in = hreadyout_out;
  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    if (capture_strobe_out === 1'b1) begin
      caps <= caps + 1;
    end
  end

  ccp_mode_control dut (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hwrite_in <= wr;
    haddr_in  <= {24'h0, a};
    htrans_in <= 2'h2;
    do @(posedge sys_clk_in); while (hready_in !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge sys_clk_in); while (hready_in !== 1'b1);
    q = hrdata_out;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd_chk

  // Selects a mode, then pulses one match and waits until it has landed.
  task automatic match(input logic [3:0] m);
    wr(`CCP_OFS_CTRL, {28'h0, m});
    cmp_match_in <= 1'b1;
    @(posedge sys_clk_in);
    cmp_match_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : match

  task automatic t_regs;
    wr(`CCP_OFS_DUTY_HI, 32'hA5);
    wr(`CCP_OFS_CTRL, 32'hFFFF_FFFF);
    rd_chk(`CCP_OFS_CTRL, 32'h3F);
    chk(pwm_mode_out, 32'h1);
    chk(pwm_duty_out, 32'h297);
    wr(8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0);
  endtask : t_regs

  task automatic t_modes;
    for (int m = 0; m < 16; m++) begin
      wr(`CCP_OFS_CTRL, 32'h20 | m);
      repeat (2) @(posedge sys_clk_in);
      chk(pwm_mode_out, m >= 12);
      chk(unit_reset_out, m == 0);
      chk(pwm_duty_out, m >= 12 ? 32'h296 : 32'h0);
    end
  endtask : t_modes

  task automatic t_compare;
    wr(`CCP_OFS_ENABLE, 32'h1);
    match(`CCP_MODE_CMP_SET);
    chk(compare_pin_out, 32'h1);
    chk(irq_out, 32'h1);
    rd_chk(`CCP_OFS_STATUS, 32'h1);
    wr(`CCP_OFS_CLEAR, 32'h3);
    rd_chk(`CCP_OFS_STATUS, 32'h0);
    chk(irq_out, 32'h0);
    match(`CCP_MODE_CMP_CLR);
    chk(compare_pin_out, 32'h0);
    rd_chk(`CCP_OFS_STATUS, 32'h1);
    match(`CCP_MODE_CMP_SET);
    wr(`CCP_OFS_CLEAR, 32'h3);
    match(`CCP_MODE_CMP_SWI);
    chk(compare_pin_out, 32'h1);
    chk(irq_out, 32'h1);
    wr(`CCP_OFS_ENABLE, 32'h0);
    rd_chk(`CCP_OFS_STATUS, 32'h1);
    chk(irq_out, 32'h0);
    wr(`CCP_OFS_CLEAR, 32'h3);
    adc_enable_in <= 1'b1;
    match(`CCP_MODE_CMP_TRIG);
    chk({timer_reset_out, adc_start_out, compare_pin_out}, 32'h7);
    @(posedge sys_clk_in);
    chk({timer_reset_out, adc_start_out}, 32'h0);
    rd_chk(`CCP_OFS_STATUS, 32'h3);
    wr(`CCP_OFS_CTRL, 32'h0);
    @(posedge sys_clk_in);
    rd_chk(`CCP_OFS_STATE, 32'h4);
  endtask : t_compare

  task automatic pulses(input int n);
    repeat (n) begin
      capture_pin_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      capture_pin_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
    repeat (6) @(posedge sys_clk_in);
  endtask : pulses

  // Re-enters a capture mode through the off mode, then counts captures.
  task automatic cap(input logic [3:0] m, input int n, input int e);
    wr(`CCP_OFS_CTRL, 32'h0);
    wr(`CCP_OFS_CTRL, {28'h0, m});
    caps = 0;
    pulses(n);
    chk(caps, e);
  endtask : cap

  task automatic t_capture;
    cap(`CCP_MODE_CAP_FALL, 3, 3);
    cap(`CCP_MODE_CAP_RISE, 3, 3);
    cap(`CCP_MODE_CAP_RISE4, 8, 2);
    cap(`CCP_MODE_CAP_RISE16, 8, 0);
    cap(`CCP_MODE_CAP_RISE16, 8, 0);
    pulses(8);
    chk(caps, 1);
  endtask : t_capture

  // Freezes the unit over a match, then resets it in mid-run.
  task automatic t_freeze;
    wr(`CCP_OFS_CTRL, {28'h0, `CCP_MODE_CMP_SET});
    ce_in        <= 1'b0;
    cmp_match_in <= 1'b1;
    @(posedge sys_clk_in);
    cmp_match_in <= 1'b0;
    chk(hreadyout_out, 32'h0);
    @(posedge sys_clk_in);
    chk(compare_pin_out, 32'h0);
    ce_in <= 1'b1;
    wr(`CCP_OFS_ENABLE, 32'h1);
    match(`CCP_MODE_CMP_SET);
    chk({compare_pin_out, irq_out}, 32'h3);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk({compare_pin_out, irq_out, unit_reset_out}, 32'h1);
    rd_chk(`CCP_OFS_STATUS, 32'h0);
  endtask : t_freeze

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_modes;
    t_compare;
    t_capture;
    t_freeze;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    end_of_test;
  end
endmodule : ccp_mode_control_decode_test

bind ccp_mode_control ccp_mode_control_assertions chk_i (.*);
